/* rtl/tcu_compare_unit.sv */
// How it works
// - CTC holds match value, clears after prescaled period
// - Flag and pin update after last matching count
// - PWM writes buffered, copied at counter top
// - Reads return active compare, never the buffer
// - Pin disconnected for codes 00/01 PWM, 00 otherwise
// - Disconnected pin keeps level, resumes from it
// - Transfer at top zeroes bits above resolution
`timescale 1ns/1ps
`include "tcu_regs.svh"

module tcu_compare_unit #(
    parameter int CNT_W = 16                  // Counter and compare width
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [2:0]       clockSelect,      // Prescaler select code
    input  wire logic [2:0]       waveMode,         // Waveform mode code
    input  wire logic [1:0]       compareOutputMode,
    input  wire logic             cmpWrEn,          // Write strobe for compare value
    input  wire logic [CNT_W-1:0] cmpWrData,
    input  wire logic             flagClr,          // Clear strobe for compare flag
    output logic [CNT_W-1:0]      counterValue,
    output logic [CNT_W-1:0]      compareValueReg,  // Active compare value read-back
    output logic                  compareFlag,
    output logic                  compareOutputPin,
    output logic                  compareOutputOe_n // Low while the unit drives the pin
);

    // ****************************************************************
    // Mode decode
    // ****************************************************************
    tcu_pkg::tcu_wave_t wave;                      // Typed view of mode input
    logic               isPwm;                     // Any PWM resolution
    logic [CNT_W-1:0]   topVal;                    // Top value and resolution mask

    // Decode mode and resolution
    always_comb begin
        wave  = tcu_pkg::tcu_wave_t'(waveMode);
        isPwm = 1'b1;
        case (wave)
            tcu_pkg::TCU_WAVE_PWM8:  topVal = CNT_W'(`TCU_TOP_PWM8);
            tcu_pkg::TCU_WAVE_PWM9:  topVal = CNT_W'(`TCU_TOP_PWM9);
            tcu_pkg::TCU_WAVE_PWM10: topVal = CNT_W'(`TCU_TOP_PWM10);
            default: begin
                // Unused codes behave as normal mode
                topVal = CNT_W'(`TCU_TOP_FULL);
                isPwm  = 1'b0;
            end
        endcase
    end

    // ****************************************************************
    // Prescaler
    // ****************************************************************
    logic [`TCU_PRE_W-1:0] preCnt_r, preCnt_nxt;   // Divider count
    logic [`TCU_PRE_W-1:0] preTc;                  // Terminal count for select
    logic                  tick;                   // One count enable

    // Terminal count and next divider value
    always_comb begin
        preTc = `TCU_PRE_TC1;
        case (clockSelect)
            `TCU_CS_DIV1:    preTc = `TCU_PRE_TC1;
            `TCU_CS_DIV8:    preTc = `TCU_PRE_TC8;
            `TCU_CS_DIV64:   preTc = `TCU_PRE_TC64;
            `TCU_CS_DIV256:  preTc = `TCU_PRE_TC256;
            `TCU_CS_DIV1024: preTc = `TCU_PRE_TC1024;
            default:         preTc = `TCU_PRE_TC1;
        endcase
        // Stopped clock never ticks
        tick       = (clockSelect != `TCU_CS_STOP) && (preCnt_r >= preTc);
        preCnt_nxt = tick ? '0 : preCnt_r + 1'b1;
        if (clockSelect == `TCU_CS_STOP) begin
            preCnt_nxt = '0;
        end
    end

    // Divider register
    always_ff @(posedge clk) begin
        if (rst) begin
            preCnt_r <= '0;
        end else begin
            preCnt_r <= preCnt_nxt;
        end
    end

    // ****************************************************************
    // Counter and direction
    // ****************************************************************
    logic [CNT_W-1:0]   cnt_r, cnt_nxt;
    tcu_pkg::tcu_dir_t  dir_r, dir_nxt;
    logic [CNT_W-1:0]   ocr_r, ocr_nxt;            // Active compare value
    logic               match;                     // Counter equals compare
    logic               atTop;                     // Counter at PWM top

    assign match = (cnt_r == ocr_r);
    assign atTop = (cnt_r == topVal);

    // Next count; compare evaluated only on the tick so a match value is
    // held for a full prescaled period before anything reacts
    always_comb begin
        cnt_nxt = cnt_r;
        dir_nxt = dir_r;
        if (tick) begin
            if (isPwm) begin
                case (dir_r)
                    tcu_pkg::TCU_DIR_UP: begin
                        if (cnt_r >= topVal) begin
                            cnt_nxt = topVal - 1'b1;
                            dir_nxt = tcu_pkg::TCU_DIR_DOWN;
                        end else begin
                            cnt_nxt = cnt_r + 1'b1;
                        end
                    end
                    tcu_pkg::TCU_DIR_DOWN: begin
                        if (cnt_r == '0) begin
                            cnt_nxt = CNT_W'(1);
                            dir_nxt = tcu_pkg::TCU_DIR_UP;
                        end else begin
                            cnt_nxt = cnt_r - 1'b1;
                        end
                    end
                    default: begin
                        dir_nxt = tcu_pkg::TCU_DIR_UP;
                    end
                endcase
                // Counter never exceeds the selected resolution
                cnt_nxt = cnt_nxt & topVal;
            end else if (wave == tcu_pkg::TCU_WAVE_CTC && match) begin
                cnt_nxt = '0;
            end else begin
                cnt_nxt = cnt_r + 1'b1;
            end
        end
        if (!isPwm) begin
            dir_nxt = tcu_pkg::TCU_DIR_UP;
        end
    end

    // Counter registers
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= CNT_W'(`TCU_RST_COUNT);
            dir_r <= tcu_pkg::TCU_DIR_UP;
        end else begin
            cnt_r <= cnt_nxt;
            dir_r <= dir_nxt;
        end
    end

    // ****************************************************************
    // Compare value and holding buffer
    // ****************************************************************
    logic [CNT_W-1:0] buf_r, buf_nxt;              // Pending PWM write
    logic             bufPend_r, bufPend_nxt;      // Buffer awaits transfer

    // Buffer writes in PWM, direct writes otherwise
    always_comb begin
        buf_nxt     = buf_r;
        bufPend_nxt = bufPend_r;
        ocr_nxt     = ocr_r;
        if (isPwm) begin
            if (tick && atTop && dir_r == tcu_pkg::TCU_DIR_UP && bufPend_r) begin
                ocr_nxt     = buf_r & topVal;
                bufPend_nxt = 1'b0;
            end
            if (cmpWrEn) begin
                buf_nxt     = cmpWrData;
                bufPend_nxt = 1'b1;
            end
        end else if (cmpWrEn) begin
            ocr_nxt     = cmpWrData;
            buf_nxt     = cmpWrData;
            bufPend_nxt = 1'b0;
        end
    end

    // Compare registers; a write left pending on leaving PWM is simply
    // kept in the buffer until a direct write or a later PWM top, which is why read-back is ocr_r
    always_ff @(posedge clk) begin
        if (rst) begin
            ocr_r     <= CNT_W'(`TCU_RST_CMP);
            buf_r     <= CNT_W'(`TCU_RST_CMP);
            bufPend_r <= 1'b0;
        end else begin
            ocr_r     <= ocr_nxt;
            buf_r     <= buf_nxt;
            bufPend_r <= bufPend_nxt;
        end
    end

    // ****************************************************************
    // Flag and output pin
    // ****************************************************************
    logic flag_r, flag_nxt;
    logic pin_r, pin_nxt;                          // Pin level, kept while off
    logic oen_r, oen_nxt;
    logic connected;                               // Unit owns the pin
    logic hit;                                     // Match seen on a tick

    assign connected = isPwm ? compareOutputMode[1]
                             : (compareOutputMode != `TCU_COM_OFF);
    assign hit       = tick && match;

    // Flag and pin next values
    always_comb begin
        flag_nxt = flag_r;
        pin_nxt  = pin_r;
        oen_nxt  = !connected;
        if (flagClr) begin
            flag_nxt = 1'b0;
        end
        if (hit) begin
            flag_nxt = 1'b1;
        end
        if (hit && connected) begin
            if (isPwm) begin
                // Clear counting up in non-inverted mode, inverse otherwise
                pin_nxt = (dir_r == tcu_pkg::TCU_DIR_DOWN) ^ compareOutputMode[0];
            end else begin
                case (compareOutputMode)
                    `TCU_COM_TOGGLE: pin_nxt = !pin_r;
                    `TCU_COM_CLEAR:  pin_nxt = 1'b0;
                    `TCU_COM_SET:    pin_nxt = 1'b1;
                    default:         pin_nxt = pin_r;
                endcase
            end
        end
    end

    // Flag and pin registers
    always_ff @(posedge clk) begin
        if (rst) begin
            flag_r <= 1'b0;
            pin_r  <= `TCU_RST_PIN;
            oen_r  <= 1'b1;
        end else begin
            flag_r <= flag_nxt;
            pin_r  <= pin_nxt;
            oen_r  <= oen_nxt;
        end
    end

    assign counterValue      = cnt_r;
    assign compareValueReg   = ocr_r;
    assign compareFlag       = flag_r;
    assign compareOutputPin  = pin_r;
    assign compareOutputOe_n = oen_r;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence matchTick;
        tick && match;
    endsequence

    sequence ctcMatchTick;
        matchTick ##0 (wave == tcu_pkg::TCU_WAVE_CTC);
    endsequence

    chk_ctc_clear: assert property (ctcMatchTick |=> cnt_r == '0)
        else $error("counter not cleared after compare match");
    chk_count_hold: assert property (!tick |=> $stable(cnt_r))
        else $error("counter moved without a prescaled tick");
    chk_flag_set: assert property (matchTick |=> flag_r)
        else $error("flag not set after matching count");
    chk_flag_early: assert property (!flag_r && !hit |=> !flag_r)
        else $error("flag set without a matching tick");
    chk_pwm_buffer: assert property (isPwm && cmpWrEn && !(tick && atTop)
                                     |=> $stable(ocr_r))
        else $error("compare changed on a buffered write");
    chk_direct_write: assert property (!isPwm && cmpWrEn
                                       |=> ocr_r == $past(cmpWrData))
        else $error("direct write did not reach compare value");
    chk_readback_active: assert property (!isPwm && !cmpWrEn
                                          |=> $stable(compareValueReg))
        else $error("read-back changed without a direct write");
    chk_pin_released: assert property (!connected |=> compareOutputOe_n)
        else $error("pin driven while disconnected");
    chk_pin_retained: assert property (!connected |=> $stable(pin_r))
        else $error("pin level changed while disconnected");
    chk_pwm8_mask: assert property (wave == tcu_pkg::TCU_WAVE_PWM8 && tick && atTop
                                    && bufPend_r && dir_r == tcu_pkg::TCU_DIR_UP
                                    && !cmpWrEn |=> ocr_r[CNT_W-1:8] == '0)
        else $error("high bits survived transfer in 8-bit PWM");
    chk_reset_pin: assert property (@(posedge clk) disable iff (1'b0)
                                    rst |=> !compareOutputPin)
        else $error("pin not low after reset");

endmodule : tcu_compare_unit

/* rtl/tcu_regs.svh */
`ifndef TCU_REGS_SVH
`define TCU_REGS_SVH

// ****************************************************************
// Clock select codes
// ****************************************************************
`define TCU_CS_STOP      3'h0
`define TCU_CS_DIV1      3'h1
`define TCU_CS_DIV8      3'h2
`define TCU_CS_DIV64     3'h3
`define TCU_CS_DIV256    3'h4
`define TCU_CS_DIV1024   3'h5

// ****************************************************************
// Prescaler terminal counts (divisor minus one)
// ****************************************************************
`define TCU_PRE_W        10
`define TCU_PRE_TC1      10'h000
`define TCU_PRE_TC8      10'h007
`define TCU_PRE_TC64     10'h03F
`define TCU_PRE_TC256    10'h0FF
`define TCU_PRE_TC1024   10'h3FF

// ****************************************************************
// PWM top values, also the resolution masks
// ****************************************************************
`define TCU_TOP_PWM8     16'h00FF
`define TCU_TOP_PWM9     16'h01FF
`define TCU_TOP_PWM10    16'h03FF
`define TCU_TOP_FULL     16'hFFFF

// ****************************************************************
// Compare output mode codes
// ****************************************************************
`define TCU_COM_OFF      2'h0
`define TCU_COM_TOGGLE   2'h1
`define TCU_COM_CLEAR    2'h2
`define TCU_COM_SET      2'h3

// ****************************************************************
// Reset values
// ****************************************************************
`define TCU_RST_COUNT    16'h0000
`define TCU_RST_CMP      16'h0000
`define TCU_RST_PIN      1'h0

`endif

/* rtl/tcu_pkg.sv */
// ****************************************************************
// Types shared by the compare unit
// ****************************************************************
package tcu_pkg;

    // Waveform generation modes
    typedef enum logic [2:0] {
        TCU_WAVE_NORMAL = 3'h0,
        TCU_WAVE_CTC    = 3'h1,
        TCU_WAVE_PWM8   = 3'h2,
        TCU_WAVE_PWM9   = 3'h3,
        TCU_WAVE_PWM10  = 3'h4
    } tcu_wave_t;

    // Counting direction, one-hot
    typedef enum logic [1:0] {
        TCU_DIR_UP   = 2'h1,
        TCU_DIR_DOWN = 2'h2
    } tcu_dir_t;

endpackage : tcu_pkg

/* dv/timer1_compare_output_unit_test.sv */
`timescale 1ns/1ps
`include "tcu_regs.svh"

// ****************************************************************
// Self-checking bench for the compare output unit
// ****************************************************************
module timer1_compare_output_unit_test;

    logic        clk;               // 200 MHz system clock
    logic        rst;               // Synchronous reset, active high
    logic [2:0]  clockSelect;       // Prescaler select
    logic [2:0]  waveMode;          // Waveform mode
    logic [1:0]  compareOutputMode; // Pin behaviour on match
    logic        cmpWrEn;           // Compare write strobe
    logic [15:0] cmpWrData;         // Compare write data
    logic        flagClr;           // Flag clear strobe
    logic [15:0] counterValue;      // Counter read-back
    logic [15:0] compareValueReg;   // Active compare read-back
    logic        compareFlag;       // Sticky match flag
    logic        compareOutputPin;  // Pin level
    logic        compareOutputOe_n; // Low while driven
    int          n_fail;            // Mismatches seen
    int          compares;          // Comparisons made
    int          n;                 // Loop counter

    tcu_compare_unit tcu_compare_unit_i (
        .clk               (clk),
        .rst               (rst),
        .clockSelect       (clockSelect),
        .waveMode          (waveMode),
        .compareOutputMode (compareOutputMode),
        .cmpWrEn           (cmpWrEn),
        .cmpWrData         (cmpWrData),
        .flagClr           (flagClr),
        .counterValue      (counterValue),
        .compareValueReg   (compareValueReg),
        .compareFlag       (compareFlag),
        .compareOutputPin  (compareOutputPin),
        .compareOutputOe_n (compareOutputOe_n)
    );

    // Free-running clock, 5 ns period
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ****************************************************************
    // Helper tasks
    // ****************************************************************
    // Advance edges, then settle 1 ns past the edge
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : step

    // Compare a 16-bit result
    task automatic cmp16(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp16

    // Compare a single-bit result
    task automatic cmp1(input string what, input logic exp, input logic got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask : cmp1

    // One-cycle write of the compare value
    task automatic write_cmp(input logic [15:0] data);
        cmpWrEn   = 1'b1;
        cmpWrData = data;
        step(1);
        cmpWrEn   = 1'b0;
    endtask : write_cmp

    // Bounded wait for a given counter value
    task automatic wait_count(input logic [15:0] value);
        n = 0;
        while (counterValue !== value && n < 2000) begin
            step(1);
            n++;
        end
        cmp1("counter reached", 1'b1, counterValue === value);
    endtask : wait_count

    // Single place that ends the run
    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test

    // Watchdog, far beyond the several hundred cycles the tests need
    initial begin
        #200000;
        n_fail++;
        end_of_test();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        n_fail            = 0;
        compares          = 0;
        rst               = 1'b1;
        clockSelect       = `TCU_CS_STOP;
        waveMode          = tcu_pkg::TCU_WAVE_NORMAL;
        compareOutputMode = `TCU_COM_OFF;
        cmpWrEn           = 1'b0;
        cmpWrData         = 16'h0000;
        flagClr           = 1'b0;
        step(2);
        rst = 1'b0;
        // Reset state of pin, enable and registers
        cmp1("pin after reset", 1'b0, compareOutputPin);             // pin starts low
        cmp1("oe_n after reset", 1'b1, compareOutputOe_n);           // code 00 released
        cmp16("compare after reset", 16'h0000, compareValueReg);     // active starts zero
        cmp1("flag after reset", 1'b0, compareFlag);                 // no match yet

        // Direct write while stopped in normal mode
        write_cmp(16'h0002);                                         // direct write
        cmp16("direct write", 16'h0002, compareValueReg);            // no buffering

        // Clear on match with divide by 8, toggle the pin
        waveMode          = tcu_pkg::TCU_WAVE_CTC;
        compareOutputMode = `TCU_COM_TOGGLE;
        clockSelect       = `TCU_CS_DIV8;
        wait_count(16'h0002);                                        // reach match value
        n = 0;
        // Flag stays low through the whole matching period
        while (counterValue === 16'h0002 && n < 20) begin
            cmp1("flag during match", 1'b0, compareFlag);            // not on first count
            step(1);
            n++;
        end
        cmp16("match value held", 16'h0008, 16'(n));                 // full period held
        cmp16("cleared after match", 16'h0000, counterValue);        // clear after last
        cmp1("flag after match", 1'b1, compareFlag);                 // flag after last
        cmp1("pin after match", 1'b1, compareOutputPin);             // pin toggled
        flagClr = 1'b1;
        step(1);
        flagClr = 1'b0;
        cmp1("flag cleared", 1'b0, compareFlag);                     // clear strobe

        // Disconnect; one match happens meanwhile, so a toggle would show
        compareOutputMode = `TCU_COM_OFF;
        step(2);
        cmp1("oe_n off in ctc", 1'b1, compareOutputOe_n);            // code 00 non-PWM
        step(30);
        cmp1("pin held off", 1'b1, compareOutputPin);                // level retained
        compareOutputMode = `TCU_COM_TOGGLE;
        wait_count(16'h0002);                                        // next match value
        cmp1("oe_n reconnected", 1'b0, compareOutputOe_n);           // code 01 non-PWM
        cmp1("pin resumed", 1'b1, compareOutputPin);                 // resume from level
        wait_count(16'h0000);                                        // count past match
        cmp1("pin toggled again", 1'b0, compareOutputPin);           // toggles from held

        // PWM8 at full rate: buffered write, masked at top
        clockSelect       = `TCU_CS_DIV1;
        waveMode          = tcu_pkg::TCU_WAVE_PWM8;
        compareOutputMode = `TCU_COM_CLEAR;
        step(2);
        cmp1("oe_n pwm code 2", 1'b0, compareOutputOe_n);            // code 10 in PWM
        write_cmp(16'hFFFF);                                         // buffered write
        cmp16("pwm write buffered", 16'h0002, compareValueReg);      // held in buffer
        wait_count(16'h00FF);                                        // reach top
        cmp16("before top transfer", 16'h0002, compareValueReg);     // not before top
        step(1);
        cmp16("top transfer masked", 16'h00FF, compareValueReg);     // bits above 8 zero
        compareOutputMode = `TCU_COM_TOGGLE;
        step(2);
        cmp1("oe_n pwm code 1", 1'b1, compareOutputOe_n);            // code 01 in PWM

        // Leave PWM with a pending buffer: read-back keeps active value
        write_cmp(16'h0010);                                         // pending write
        waveMode          = tcu_pkg::TCU_WAVE_NORMAL;
        compareOutputMode = `TCU_COM_OFF;
        step(3);
        cmp16("pending not read", 16'h00FF, compareValueReg);        // active read-back
        cmp1("oe_n normal off", 1'b1, compareOutputOe_n);            // code 00 non-PWM
        write_cmp(16'h1234);                                         // direct write
        cmp16("direct after pwm", 16'h1234, compareValueReg);        // immediate update

        // PWM9: buffered write, masked to nine bits at top
        waveMode          = tcu_pkg::TCU_WAVE_PWM9;
        write_cmp(16'hFFFF);                                         // buffered write
        cmp16("pwm9 write buffered", 16'h1234, compareValueReg);     // held in buffer
        wait_count(16'h01FF);                                        // reach top
        step(1);
        cmp16("pwm9 top masked", 16'h01FF, compareValueReg);         // bits above 9 zero

        // Back to normal; set the pin high on a match so reset has work
        waveMode          = tcu_pkg::TCU_WAVE_NORMAL;
        write_cmp(16'h0210);                                         // direct write
        cmp16("direct after pwm9", 16'h0210, compareValueReg);       // immediate update
        compareOutputMode = `TCU_COM_SET;
        wait_count(16'h0211);                                        // count past match
        cmp1("pin set on match", 1'b1, compareOutputPin);            // pin after match
        cmp1("flag before reset 2", 1'b1, compareFlag);              // flag after match

        // Second reset mid-run
        rst = 1'b1;
        step(1);
        rst = 1'b0;
        cmp1("pin after reset 2", 1'b0, compareOutputPin);           // pin starts low
        cmp16("compare after reset 2", 16'h0000, compareValueReg);   // active cleared
        cmp1("flag after reset 2", 1'b0, compareFlag);               // flag cleared
        end_of_test();
    end

endmodule : timer1_compare_output_unit_test
